/* io_bus_ctrl.sv */
// processor-side I/O bus pulse, data and word-count overflow control
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "io_bus_defines.svh"

module io_bus_ctrl
  import io_bus_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  // I/O bus data lines, index 17 is line one
  input  wire logic [`WORD_W-1:0]   data_i,
  output logic [`WORD_W-1:0]        data_o,
  output logic                      data_oe_o,
  // I/O bus control
  input  wire logic                 skip_request_n_i,
  output logic                      io_sync_o,
  output logic                      first_control_pulse_o,
  output logic                      second_control_pulse_o,
  output logic                      third_control_pulse_o,
  output logic                      word_count_overflow_o,
  output logic                      bus_clear_pulse_o
);

  // ----------------------------------------------------------------------
  // timing and pin synchronisers
  // ----------------------------------------------------------------------
  logic                slot;
  logic [`PHASE_W-1:0] phase;

  io_sync_timer u_timer (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .io_sync_o (io_sync_o),
    .slot_o    (slot),
    .phase_o   (phase)
  );

  logic [`WORD_W-1:0] data_meta;
  logic [`WORD_W-1:0] data_sync;
  logic               skip_meta_n;
  logic               skip_sync_n;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_meta   <= `RST_WORD;
      data_sync   <= `RST_WORD;
      skip_meta_n <= 1'b1;
      skip_sync_n <= 1'b1;
    end else if (ce_i) begin
      data_meta   <= data_i;
      data_sync   <= data_meta;
      skip_meta_n <= skip_request_n_i;
      skip_sync_n <= skip_meta_n;
    end
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  seq_state_t          state;
  logic                is_dch;
  logic                dir_in;
  logic                incr_mem;
  logic                wc_zero;
  logic                skip_seen;
  logic                enable;
  logic                clear_pend;
  logic [`WORD_W-1:0]  instr;
  logic [`WORD_W-1:0]  acc_out;
  logic [`WORD_W-1:0]  acc_in;
  logic [`WORD_W-1:0]  word_count;
  logic [`WORD_W-1:0]  dch_out;
  logic [`WORD_W-1:0]  dch_in;
  logic [`WORD_W-1:0]  pc;
  logic [`IRQ_W-1:0]   irq_status;
  logic [`IRQ_W-1:0]   irq_mask;

  seq_state_t          next_state;
  logic                next_is_dch;
  logic                next_dir_in;
  logic                next_incr_mem;
  logic                next_wc_zero;
  logic                next_skip_seen;
  logic                next_enable;
  logic                next_clear_pend;
  logic [`WORD_W-1:0]  next_instr;
  logic [`WORD_W-1:0]  next_acc_out;
  logic [`WORD_W-1:0]  next_acc_in;
  logic [`WORD_W-1:0]  next_word_count;
  logic [`WORD_W-1:0]  next_dch_out;
  logic [`WORD_W-1:0]  next_dch_in;
  logic [`WORD_W-1:0]  next_pc;
  logic [`IRQ_W-1:0]   next_irq_status;
  logic [`IRQ_W-1:0]   next_irq_mask;
  logic [`IRQ_W-1:0]   irq_set;
  logic [31:0]         next_dat;
  logic                next_ack;
  logic                next_first;
  logic                next_second;
  logic                next_third;
  logic                next_oflo;
  logic                next_clear_out;
  logic                next_oe;
  logic [`WORD_W-1:0]  next_data_o;
  logic                in_window;
  logic                wr;
  logic                busy;
  logic [`WORD_W-1:0]  wdat;

  function automatic logic hit(input logic [`ADR_W-1:0] adr, input logic [`ADR_W-1:0] off);
    hit = adr[`ADR_W-1:2] == off[`ADR_W-1:2];
  endfunction

  function automatic logic [31:0] word32(input logic [`WORD_W-1:0] w);
    word32 = {14'h0000, w};
  endfunction

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  always_comb begin
    busy            = state != ST_IDLE;
    // write lands on the edge where the master samples ack high
    wr              = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (&wb_sel_i[2:0]);
    wdat            = wb_dat_i[`WORD_W-1:0];
    in_window       = (phase >= `PULSE_START)
                      && (phase < `PULSE_START + `PHASE_W'(`SYNC_WIDTH_CYC));
    next_state      = state;
    next_is_dch     = is_dch;
    next_dir_in     = dir_in;
    next_incr_mem   = incr_mem;
    next_wc_zero    = wc_zero;
    next_skip_seen  = skip_seen;
    next_enable     = enable;
    next_clear_pend = clear_pend;
    next_instr      = instr;
    next_acc_out    = acc_out;
    next_acc_in     = acc_in;
    next_word_count = word_count;
    next_dch_out    = dch_out;
    next_dch_in     = dch_in;
    next_pc         = pc;
    next_irq_mask   = irq_mask;
    irq_set         = '0;

    // register writes; starts are ignored while a sequence runs
    if (wr && hit(wb_adr_i, `OFF_CTRL)) begin
      next_enable = wdat[`CTRL_ENABLE];
      if (wdat[`CTRL_CLEAR]) begin
        next_clear_pend = 1'b1;
      end
    end
    if (wr && hit(wb_adr_i, `OFF_INSTR) && !busy && enable) begin
      next_instr     = wdat;
      next_is_dch    = 1'b0;
      next_skip_seen = 1'b0;
      next_state     = ST_ARM;
    end
    if (wr && hit(wb_adr_i, `OFF_DCH_CMD) && !busy && enable) begin
      next_is_dch   = 1'b1;
      next_dir_in   = wdat[`CMD_DIR_IN];
      next_incr_mem = wdat[`CMD_INCR_MEM];
      next_state    = ST_ARM;
    end
    if (wr && hit(wb_adr_i, `OFF_ACC_OUT)) next_acc_out = wdat;
    if (wr && hit(wb_adr_i, `OFF_WORD_COUNT) && !busy) next_word_count = wdat;
    if (wr && hit(wb_adr_i, `OFF_DCH_OUT)) next_dch_out = wdat;
    if (wr && hit(wb_adr_i, `OFF_PC) && !busy) next_pc = wdat;
    if (wr && hit(wb_adr_i, `OFF_IRQ_MASK)) next_irq_mask = wb_dat_i[`IRQ_W-1:0];

    // sequencer advances once per sync slot
    if (slot) begin
      unique case (state)
        ST_IDLE: begin
        end
        ST_ARM: begin
          next_state = ST_SLOT1;
          if (is_dch) begin
            next_word_count = word_count + 1'b1;
            next_wc_zero    = (word_count + 1'b1) == '0;
          end
        end
        ST_SLOT1: next_state = (is_dch && incr_mem) ? ST_DONE : ST_SLOT2;
        ST_SLOT2: next_state = (is_dch && dir_in) ? ST_DONE : ST_SLOT3;
        ST_SLOT3: next_state = ST_DONE;
        ST_DONE: begin
        end
      endcase
    end
    if (state == ST_DONE) begin
      next_state = ST_IDLE;
      if (is_dch) begin
        irq_set[`IRQ_DCH_DONE] = 1'b1;
        irq_set[`IRQ_OVERFLOW] = wc_zero;
      end else begin
        irq_set[`IRQ_INSTR_DONE] = 1'b1;
        irq_set[`IRQ_SKIP]       = skip_seen;
        next_pc                  = skip_seen ? pc + 1'b1 : pc;
      end
    end
    // skip returned during the first pulse, seen two cycles late through the synchroniser
    if (state == ST_SLOT1 && !is_dch && instr[`BIT_FIRST_PULSE] && !skip_sync_n
        && phase >= `PULSE_START + 2'h2) begin
      next_skip_seen = 1'b1;
    end
    if (state == ST_SLOT2 && phase == `CAPTURE_PHASE) begin
      if (is_dch) next_dch_in = data_sync;
      else if (instr[`BIT_SECOND_PULSE]) next_acc_in = data_sync;
    end

    // bus clear waits for a slot and aborts any running sequence
    next_clear_out = bus_clear_pulse_o;
    if (slot && clear_pend) begin
      next_clear_out  = 1'b1;
      next_clear_pend = 1'b0;
      next_state      = ST_IDLE;
    end else if (phase == `PHASE_W'(`SYNC_WIDTH_CYC - 1)) begin
      next_clear_out = 1'b0;
    end

    // pulses sit in a fixed window of the slot
    next_first  = state == ST_SLOT1 && !is_dch && instr[`BIT_FIRST_PULSE] && in_window;
    next_second = state == ST_SLOT2 && in_window
                  && (is_dch ? dir_in : instr[`BIT_SECOND_PULSE]);
    next_third  = state == ST_SLOT3 && in_window
                  && (is_dch || instr[`BIT_THIRD_PULSE]);
    next_oflo   = next_state == ST_SLOT1 && is_dch && next_wc_zero;
    // drive the whole output slot so data is settled around the third pulse
    next_oe     = next_state == ST_SLOT3;
    next_data_o = is_dch ? dch_out : acc_out;

    // sticky status, set beats a simultaneous write-one clear
    for (int i = 0; i < `IRQ_W; i++) begin
      next_irq_status[i] = irq_status[i];
      if (wr && hit(wb_adr_i, `OFF_IRQ_STATUS) && wb_dat_i[i]) next_irq_status[i] = 1'b0;
      if (irq_set[i]) next_irq_status[i] = 1'b1;
    end

    // read mux; unmapped addresses answer zero
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h00000000;
    if (hit(wb_adr_i, `OFF_CTRL)) next_dat = {31'h00000000, enable};
    if (hit(wb_adr_i, `OFF_INSTR)) next_dat = word32(instr);
    if (hit(wb_adr_i, `OFF_ACC_OUT)) next_dat = word32(acc_out);
    if (hit(wb_adr_i, `OFF_ACC_IN)) next_dat = word32(acc_in);
    if (hit(wb_adr_i, `OFF_DCH_CMD)) next_dat = {29'h00000000, busy, incr_mem, dir_in};
    if (hit(wb_adr_i, `OFF_WORD_COUNT)) next_dat = word32(word_count);
    if (hit(wb_adr_i, `OFF_DCH_OUT)) next_dat = word32(dch_out);
    if (hit(wb_adr_i, `OFF_DCH_IN)) next_dat = word32(dch_in);
    if (hit(wb_adr_i, `OFF_PC)) next_dat = word32(pc);
    if (hit(wb_adr_i, `OFF_IRQ_STATUS)) next_dat = {28'h0000000, irq_status};
    if (hit(wb_adr_i, `OFF_IRQ_MASK)) next_dat = {28'h0000000, irq_mask};
    if (hit(wb_adr_i, `OFF_STATUS)) next_dat = {29'h00000000, enable, skip_seen, busy};
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state                  <= ST_IDLE;
      is_dch                 <= 1'b0;
      dir_in                 <= 1'b0;
      incr_mem               <= 1'b0;
      wc_zero                <= 1'b0;
      skip_seen              <= 1'b0;
      enable                 <= 1'b0;
      clear_pend             <= 1'b0;
      instr                  <= `RST_WORD;
      acc_out                <= `RST_WORD;
      acc_in                 <= `RST_WORD;
      word_count             <= `RST_WORD;
      dch_out                <= `RST_WORD;
      dch_in                 <= `RST_WORD;
      pc                     <= `RST_WORD;
      irq_status             <= `RST_IRQ;
      irq_mask               <= `RST_IRQ;
      wb_dat_o               <= 32'h00000000;
      wb_ack_o               <= 1'b0;
      irq_o                  <= 1'b0;
      data_o                 <= `RST_WORD;
      data_oe_o              <= 1'b0;
      first_control_pulse_o  <= 1'b0;
      second_control_pulse_o <= 1'b0;
      third_control_pulse_o  <= 1'b0;
      word_count_overflow_o  <= 1'b0;
      bus_clear_pulse_o      <= 1'b0;
    end else if (ce_i) begin
      state                  <= next_state;
      is_dch                 <= next_is_dch;
      dir_in                 <= next_dir_in;
      incr_mem               <= next_incr_mem;
      wc_zero                <= next_wc_zero;
      skip_seen              <= next_skip_seen;
      enable                 <= next_enable;
      clear_pend             <= next_clear_pend;
      instr                  <= next_instr;
      acc_out                <= next_acc_out;
      acc_in                 <= next_acc_in;
      word_count             <= next_word_count;
      dch_out                <= next_dch_out;
      dch_in                 <= next_dch_in;
      pc                     <= next_pc;
      irq_status             <= next_irq_status;
      irq_mask               <= next_irq_mask;
      wb_dat_o               <= next_dat;
      wb_ack_o               <= next_ack;
      irq_o                  <= |(next_irq_status & next_irq_mask);
      data_o                 <= next_data_o;
      data_oe_o              <= next_oe;
      first_control_pulse_o  <= next_first;
      second_control_pulse_o <= next_second;
      third_control_pulse_o  <= next_third;
      word_count_overflow_o  <= next_oflo;
      bus_clear_pulse_o      <= next_clear_out;
    end
  end

endmodule

/* io_bus_ctrl_chk.sv */
// port-level assertion checker for the I/O bus control
`timescale 1ns/1ps
`include "io_bus_defines.svh"

module io_bus_ctrl_chk (
  // clock, reset, enable
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  // wishbone
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [`ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                irq_o,
  // bus lines and control
  input wire logic [`WORD_W-1:0]  data_i,
  input wire logic [`WORD_W-1:0]  data_o,
  input wire logic                data_oe_o,
  input wire logic                skip_request_n_i,
  input wire logic                io_sync_o,
  input wire logic                first_control_pulse_o,
  input wire logic                second_control_pulse_o,
  input wire logic                third_control_pulse_o,
  input wire logic                word_count_overflow_o,
  input wire logic                bus_clear_pulse_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  AST_SYNC_WIDTH: assert property ($rose(io_sync_o) |-> io_sync_o[*3] ##1 !io_sync_o)
    else $error("sync pulse width wrong");
  // period holds only while ce_i stays high
  AST_SYNC_PERIOD: assert property ($rose(io_sync_o) |-> ##10 $rose(io_sync_o))
    else $error("sync pulse period wrong");
  AST_FIRST_WIDTH: assert property ($rose(first_control_pulse_o) |->
    first_control_pulse_o[*3] ##1 !first_control_pulse_o)
    else $error("first pulse width wrong");
  AST_PULSE_PHASE: assert property ($rose(second_control_pulse_o) ||
    $rose(third_control_pulse_o) |-> $past(io_sync_o, 2) && !$past(io_sync_o, 1))
    else $error("pulse out of slot phase");
  AST_PULSE_OFF_SYNC: assert property (first_control_pulse_o || second_control_pulse_o ||
    third_control_pulse_o |-> !io_sync_o)
    else $error("pulse overlaps sync");
  AST_OFLO_SLOT: assert property ($rose(word_count_overflow_o) |->
    word_count_overflow_o[*8] ##1 word_count_overflow_o ##1 word_count_overflow_o
    ##1 !word_count_overflow_o)
    else $error("overflow not one slot long");
  AST_OE_THIRD: assert property ($rose(third_control_pulse_o) |-> data_oe_o)
    else $error("write pulse without driven lines");
  AST_OE_NO_READ: assert property (data_oe_o |->
    !first_control_pulse_o && !second_control_pulse_o)
    else $error("lines driven during read or skip pulse");
  AST_CLEAR_SYNC: assert property (bus_clear_pulse_o |-> io_sync_o)
    else $error("bus clear not aligned with sync");
  AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind io_bus_ctrl io_bus_ctrl_chk chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
  .skip_request_n_i(skip_request_n_i), .io_sync_o(io_sync_o),
  .first_control_pulse_o(first_control_pulse_o), .second_control_pulse_o(second_control_pulse_o),
  .third_control_pulse_o(third_control_pulse_o), .word_count_overflow_o(word_count_overflow_o),
  .bus_clear_pulse_o(bus_clear_pulse_o));

/* io_bus_defines.svh */
// register offsets, field positions, reset values and timing counts of the I/O bus control
`ifndef IO_BUS_DEFINES_SVH
`define IO_BUS_DEFINES_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define WORD_W          18
`define MSB_LINE        17
`define BIT_FIRST_PULSE 17
`define BIT_SECOND_PULSE 16
`define BIT_THIRD_PULSE 15

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define SYNC_PERIOD_NS  1000
`define SYNC_WIDTH_NS   250
`define SYNC_PERIOD_CYC ((`SYNC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_WIDTH_CYC  ((`SYNC_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_W         4
`define PULSE_START     4'h3
`define CAPTURE_PHASE   4'h7

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ADR_W           8
`define OFF_CTRL        8'h00
`define OFF_INSTR       8'h04
`define OFF_ACC_OUT     8'h08
`define OFF_ACC_IN      8'h0c
`define OFF_DCH_CMD     8'h10
`define OFF_WORD_COUNT  8'h14
`define OFF_DCH_OUT     8'h18
`define OFF_DCH_IN      8'h1c
`define OFF_PC          8'h20
`define OFF_IRQ_STATUS  8'h24
`define OFF_IRQ_MASK    8'h28
`define OFF_STATUS      8'h2c

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CTRL_ENABLE     0
`define CTRL_CLEAR      1
`define CMD_DIR_IN      0
`define CMD_INCR_MEM    1
`define IRQ_W           4
`define IRQ_INSTR_DONE  0
`define IRQ_SKIP        1
`define IRQ_DCH_DONE    2
`define IRQ_OVERFLOW    3
`define STAT_BUSY       0
`define STAT_SKIP       1
`define STAT_ENABLE     2
`define RST_WORD        18'h00000
`define RST_IRQ         4'h0

`endif

/* io_bus_pkg.sv */
// types of the I/O bus control
package io_bus_pkg;

  // gray codes along idle, arm, slot1, slot2, slot3, done
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ARM   = 3'h1,
    ST_SLOT1 = 3'h3,
    ST_SLOT2 = 3'h2,
    ST_SLOT3 = 3'h6,
    ST_DONE  = 3'h7
  } seq_state_t;

endpackage

/* io_periph_model.sv */
// behavioural peripheral controller on the far side of the I/O bus
`timescale 1ns/1ps

module io_periph_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bus control seen from the processor
  input  wire logic        first_pulse_i,
  input  wire logic        second_pulse_i,
  input  wire logic        third_pulse_i,
  input  wire logic        overflow_i,
  input  wire logic        bus_clear_i,
  input  wire logic [17:0] line_i,
  // bench controls
  input  wire logic        skip_flag_i,
  input  wire logic [17:0] tx_word_i,
  // outputs
  output logic [17:0]      drive_o,
  output logic             skip_request_n_o,
  output logic [17:0]      rx_word_o,
  output logic             rx_strobe_o,
  output logic             block_done_o
);
  logic [1:0]  hold;
  logic [17:0] junk;
  logic        p3_d;

  // flag is only tested here, never cleared by the same pulse
  assign skip_request_n_o = !(first_pulse_i && skip_flag_i);
  // released lines toggle so a stale value cannot pass
  assign drive_o = (second_pulse_i || hold != 2'h0) ? tx_word_i : junk;

  always_ff @(posedge clk_i) begin
    if (rst_i || bus_clear_i) begin
      hold         <= 2'h0;
      junk         <= 18'h2aaaa;
      p3_d         <= 1'b0;
      rx_word_o    <= 18'h0;
      rx_strobe_o  <= 1'b0;
      block_done_o <= 1'b0;
    end else begin
      p3_d        <= third_pulse_i;
      rx_strobe_o <= p3_d && !third_pulse_i;
      junk        <= ~drive_o;
      if (third_pulse_i)
        rx_word_o <= line_i;
      if (overflow_i)
        block_done_o <= 1'b1;
      if (second_pulse_i)
        hold <= 2'h3;
      else if (hold != 2'h0)
        hold <= hold - 2'h1;
    end
  end
endmodule

/* io_sync_timer.sv */
// free-running I/O sync pulse and slot phase generator
`timescale 1ns/1ps
`include "io_bus_defines.svh"

module io_sync_timer (
  // clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  // timing outputs
  output logic                      io_sync_o,
  output logic                      slot_o,
  output logic [`PHASE_W-1:0]       phase_o
);

  localparam logic [`PHASE_W-1:0] LAST_PHASE = `PHASE_W'(`SYNC_PERIOD_CYC - 1);
  localparam logic [`PHASE_W-1:0] WIDTH      = `PHASE_W'(`SYNC_WIDTH_CYC);

  logic [`PHASE_W-1:0] next_phase;
  logic                next_sync;
  logic                next_slot;

  always_comb begin
    next_phase = (phase_o == LAST_PHASE) ? '0 : phase_o + 1'b1;
    next_sync  = next_phase < WIDTH;
    next_slot  = next_phase == '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o   <= LAST_PHASE;
      io_sync_o <= 1'b0;
      slot_o    <= 1'b0;
    end else if (ce_i) begin
      phase_o   <= next_phase;
      io_sync_o <= next_sync;
      slot_o    <= next_slot;
    end
  end

endmodule

/* tb_top.sv */
// self-checking testbench of the I/O bus control
`timescale 1ns/1ps
`include "io_bus_defines.svh"

module tb_top;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ce_i = 1'b1;
  logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [`ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0, wb_dat_o;
  logic              wb_ack_o, irq_o, data_oe_o, skip_n, io_sync_o, clr, ovf, p1, p2, p3;
  logic [17:0]       data_i, data_o, dev_drive, rx_word, tx_word = 18'h0;
  logic              skip_flag = 1'b0, rx_strobe, block_done;
  logic [3:0]        prv = 4'h0;
  int                cnt [4] = '{0, 0, 0, 0};
  int                base [4];
  int                n_errors = 0, compares = 0;
  integer            seed = 32'h737cbfcb;
  logic [31:0]       exp_rd [$];
  logic [17:0]       exp_rx [$];

  always #50 clk_i = ~clk_i;
  assign data_i = data_oe_o ? data_o : dev_drive;

  io_bus_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .skip_request_n_i(skip_n),
    .io_sync_o(io_sync_o), .first_control_pulse_o(p1), .second_control_pulse_o(p2),
    .third_control_pulse_o(p3), .word_count_overflow_o(ovf), .bus_clear_pulse_o(clr));
  io_periph_model dev (.clk_i(clk_i), .rst_i(rst_i), .first_pulse_i(p1), .second_pulse_i(p2),
    .third_pulse_i(p3), .overflow_i(ovf), .bus_clear_i(clr), .line_i(data_i),
    .skip_flag_i(skip_flag), .tx_word_i(tx_word), .drive_o(dev_drive),
    .skip_request_n_o(skip_n), .rx_word_o(rx_word), .rx_strobe_o(rx_strobe),
    .block_done_o(block_done));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    wb(a, 1'b0, 32'h0);
  endtask

  task automatic pulses(input logic [3:0] ep);
    for (int k = 0; k < 4; k++)
      check("pulse count", cnt[k] - base[k], {31'h0, ep[k]});
  endtask

  // run an operation to its done irq, then clear it
  task automatic op(input logic [7:0] a, input logic [17:0] c, input logic [3:0] ep,
                    input logic [3:0] es);
    base = cnt;
    wr(a, {14'h0, c});
    for (int t = 0; t < 200 && irq_o !== 1'b1; t++) @(posedge clk_i);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    pulses(ep);
    rd(`OFF_IRQ_STATUS, {28'h0, es});
    wr(`OFF_IRQ_STATUS, 32'hf);
  endtask

  // ----------------------------------------------------------------------
  // result watchers
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    prv <= {ovf, p3, p2, p1};
    for (int k = 0; k < 4; k++)
      if (prv[k] === 1'b0 && {ovf, p3, p2, p1} >> k & 4'h1) cnt[k] <= cnt[k] + 1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check("read data", wb_dat_o,
            exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    if (rx_strobe === 1'b1)
      check("rx word", {14'h0, rx_word},
            {14'h0, exp_rx.size() ? exp_rx.pop_front() : 18'hx});
  end

  initial begin
    #3000000;
    n_errors++;
    give_verdict();
  end

  initial begin
    logic [17:0] acc, tx;
    logic        f;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`OFF_STATUS, 32'h0);
    rd(`OFF_IRQ_STATUS, 32'h0);
    rd(`OFF_WORD_COUNT, 32'h0);
    rd(8'h3c, 32'h0);
    // disabled bus ignores instructions
    base = cnt;
    wr(`OFF_INSTR, 32'h38000);
    repeat (50) @(posedge clk_i);
    pulses(4'h0);
    wr(`OFF_CTRL, 32'h1);
    // masked event stays quiet until unmasked
    wr(`OFF_IRQ_MASK, 32'h0);
    wr(`OFF_INSTR, 32'h0);
    repeat (60) @(posedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rd(`OFF_IRQ_STATUS, 32'h1);
    wr(`OFF_IRQ_MASK, 32'h5);
    repeat (3) @(posedge clk_i);
    check("irq unmasked", {31'h0, irq_o}, 32'h1);
    wr(`OFF_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    // every pulse bit combination of a device instruction
    for (int i = 0; i < 8; i++) begin
      acc = 18'($random(seed));
      tx = 18'($random(seed));
      f = 1'($random(seed));
      tx_word <= tx;
      skip_flag <= f;
      wr(`OFF_ACC_OUT, {14'h0, acc});
      wr(`OFF_PC, 32'h0);
      if (i[0]) exp_rx.push_back(acc);
      op(`OFF_INSTR, {i[2:0], 15'h0}, {1'b0, i[0], i[1], i[2]},
         {2'b0, i[2] & f, 1'b1});
      rd(`OFF_PC, {31'h0, i[2] & f});
      if (i[1]) rd(`OFF_ACC_IN, {14'h0, tx});
    end
    // channel out of memory with last word
    acc = 18'($random(seed));
    wr(`OFF_DCH_OUT, {14'h0, acc});
    wr(`OFF_WORD_COUNT, 32'h3ffff);
    exp_rx.push_back(acc);
    op(`OFF_DCH_CMD, 18'h0, 4'b1100, 4'hc);
    rd(`OFF_WORD_COUNT, 32'h0);
    check("block done", {31'h0, block_done}, 32'h1);
    // channel into memory, count not yet exhausted
    tx = 18'($random(seed));
    tx_word <= tx;
    wr(`OFF_WORD_COUNT, 32'h3fffd);
    op(`OFF_DCH_CMD, 18'h1, 4'b0010, 4'h4);
    rd(`OFF_DCH_IN, {14'h0, tx});
    rd(`OFF_WORD_COUNT, 32'h3fffe);
    // increment memory cycle reaching zero
    wr(`OFF_WORD_COUNT, 32'h3ffff);
    op(`OFF_DCH_CMD, 18'h2, 4'b1000, 4'hc);
    // bus clear resets the peripheral
    wr(`OFF_CTRL, 32'h3);
    for (int t = 0; t < 40 && clr !== 1'b1; t++) @(posedge clk_i);
    check("bus clear", {31'h0, clr}, 32'h1);
    repeat (4) @(posedge clk_i);
    check("peripheral cleared", {13'h0, block_done, rx_word}, 32'h0);
    check("notes left", exp_rd.size() + exp_rx.size(), 32'h0);
    give_verdict();
  end
endmodule
